// ### pmr_pkg.sv
// Purpose: Constants and carrier types for the power monitor result registers
// Assumes: One 20 MHz clock, synchronous active-high reset
// Notes: Register offsets index whole 16-bit registers on the management port
package pmr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] PMR_ADDR_BUS_VOLT = 8'h02;
  localparam logic [7:0] PMR_ADDR_POWER = 8'h03;
  localparam logic [7:0] PMR_ADDR_CURRENT = 8'h04;
  localparam logic [7:0] PMR_ADDR_CAL = 8'h05;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int PMR_VOLT_LSB = 3;
  localparam int PMR_READY_BIT = 1;
  localparam int PMR_OVF_BIT = 0;
  localparam logic [15:0] PMR_RESET_VALUE = 16'h0000;
  localparam logic [15:0] PMR_CAL_WR_MASK = 16'hfffe;

  // ----------------------------------------
  // Arithmetic constants
  // ----------------------------------------
  localparam int PMR_CURRENT_SHIFT = 12;
  localparam logic [16:0] PMR_POWER_DIVISOR = 17'h01388;
  localparam logic [16:0] PMR_POWER_MAX = 17'h0ffff;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {PMR_IDLE, PMR_CURRENT, PMR_POWER} pmr_state_type;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [7:0] addr;
    logic [15:0] wr_data;
  } pmr_host_req_type;

  typedef struct packed {
    logic conv_done;
    logic range_16v;
    logic [12:0] bus_volt;
    logic [15:0] shunt_volt;
  } pmr_conv_type;

endpackage

// ### pmr_regs.sv
// Purpose: Result and calibration registers of the power monitor
// Assumes: Host port and converter logic run on clk; no synchronisers needed
// Notes: Read data appears one cycle after rd_en; math runs in two cycles
`timescale 1ns/1ns
`default_nettype none

module pmr_regs
  import pmr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host register port
  input wire pmr_host_req_type host_req,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // Converter results
  input wire pmr_conv_type conv,
  // Operating mode write event
  input wire logic mode_wr,
  input wire logic mode_off,
  // Flags for observation
  output logic conversion_ready_flag,
  output logic math_overflow_flag
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pmr_state_type state;
    logic [15:0] bus_voltage_result;
    logic [15:0] power_result;
    logic [15:0] current_result;
    logic [15:0] current_scale_setting;
    logic [12:0] supply_rail_voltage;
    logic [15:0] shunt_hold;
    logic ready;
    logic ovf;
    logic ovf_pending;
    logic [15:0] rd_data;
    logic rd_valid;
  } pmr_regs_type;

  pmr_regs_type s_reg;
  pmr_regs_type s_next;

  // ----------------------------------------
  // Arithmetic
  // ----------------------------------------
  logic signed [32:0] cur_prod;
  logic signed [32:0] cur_scaled;
  logic cur_ovf;
  logic [15:0] cur_abs;
  logic [28:0] pwr_prod;
  logic [28:0] pwr_quot;
  logic pwr_ovf;
  logic [15:0] bus_word;

  // Current from held shunt value and calibration
  assign cur_prod = $signed(s_reg.shunt_hold) * $signed({17'h00000, s_reg.current_scale_setting});
  assign cur_scaled = cur_prod >>> PMR_CURRENT_SHIFT;
  assign cur_ovf = (cur_scaled > 33'sh000007fff) || (cur_scaled < -33'sh000008000);

  // Power from current magnitude and bus voltage
  assign cur_abs = s_reg.current_result[15] ? 16'(-s_reg.current_result) : s_reg.current_result;
  assign pwr_prod = 29'(cur_abs) * 29'(s_reg.supply_rail_voltage);
  assign pwr_quot = pwr_prod / 29'(PMR_POWER_DIVISOR);
  assign pwr_ovf = pwr_quot > 29'(PMR_POWER_MAX);

  // Bus voltage word, with range-dependent top bit
  always_comb
  begin
    bus_word = PMR_RESET_VALUE;
    if (conv.range_16v)
    begin
      bus_word[14:PMR_VOLT_LSB] = conv.bus_volt[11:0];
    end
    else
    begin
      bus_word[15:PMR_VOLT_LSB] = conv.bus_volt;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.rd_valid = 1'b0;

    // Register reads, served from stored values at any time
    if (host_req.rd_en)
    begin
      s_next.rd_valid = 1'b1;
      case (host_req.addr)
        PMR_ADDR_BUS_VOLT:
        begin
          s_next.rd_data = s_reg.bus_voltage_result;
          s_next.rd_data[PMR_READY_BIT] = s_reg.ready;
          s_next.rd_data[PMR_OVF_BIT] = s_reg.ovf;
        end
        PMR_ADDR_POWER:
        begin
          s_next.rd_data = s_reg.power_result;
          s_next.ready = 1'b0;
        end
        PMR_ADDR_CURRENT:
        begin
          s_next.rd_data = s_reg.current_result;
        end
        PMR_ADDR_CAL:
        begin
          s_next.rd_data = s_reg.current_scale_setting;
        end
        default:
        begin
          s_next.rd_data = PMR_RESET_VALUE;
        end
      endcase
    end

    // Only the calibration register takes writes
    if (host_req.wr_en && host_req.addr == PMR_ADDR_CAL)
    begin
      s_next.current_scale_setting = host_req.wr_data & PMR_CAL_WR_MASK;
    end
    // Writes to other offsets fall through unused

    // Mode change clears ready unless it turns the converter off
    if (mode_wr && !mode_off)
    begin
      s_next.ready = 1'b0;
    end

    // Conversion pipeline
    case (s_reg.state)
      PMR_IDLE:
      begin
        if (conv.conv_done)
        begin
          s_next.bus_voltage_result = bus_word;
          s_next.supply_rail_voltage = conv.range_16v ? {1'b0, conv.bus_volt[11:0]} : conv.bus_volt;
          s_next.shunt_hold = conv.shunt_volt;
          s_next.state = PMR_CURRENT;
        end
      end
      PMR_CURRENT:
      begin
        s_next.current_result = cur_scaled[15:0];
        s_next.ovf_pending = cur_ovf;
        s_next.state = PMR_POWER;
      end
      PMR_POWER:
      begin
        s_next.power_result = pwr_quot[15:0];
        s_next.ovf = s_reg.ovf_pending || pwr_ovf;
        s_next.ready = 1'b1;
        s_next.state = PMR_IDLE;
      end
      default:
      begin
        s_next.state = PMR_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg.state <= PMR_IDLE;
      s_reg.bus_voltage_result <= PMR_RESET_VALUE;
      s_reg.power_result <= PMR_RESET_VALUE;
      s_reg.current_result <= PMR_RESET_VALUE;
      s_reg.current_scale_setting <= PMR_RESET_VALUE;
      s_reg.supply_rail_voltage <= 13'h0000;
      s_reg.shunt_hold <= PMR_RESET_VALUE;
      s_reg.ready <= 1'b0;
      s_reg.ovf <= 1'b0;
      s_reg.ovf_pending <= 1'b0;
      s_reg.rd_data <= PMR_RESET_VALUE;
      s_reg.rd_valid <= 1'b0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rd_data = s_reg.rd_data;
  assign rd_valid = s_reg.rd_valid;
  assign conversion_ready_flag = s_reg.ready;
  assign math_overflow_flag = s_reg.ovf;

endmodule

`default_nettype wire

// ### pmr_regs_monitor.sv
// Purpose: Port checker for pmr_regs
// Assumes: One clock, rst synchronous
// Notes: Bound into every pmr_regs
`timescale 1ns/1ns
`default_nettype none
module pmr_regs_monitor
  import pmr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire pmr_host_req_type host_req,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire pmr_conv_type conv,
  input wire logic mode_wr,
  input wire logic mode_off,
  input wire logic conversion_ready_flag,
  input wire logic math_overflow_flag
);
  // --------------------
  // Checks
  // --------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_conv;
    conv.conv_done;
  endsequence
  sequence s_no_set;
    !$past(conv.conv_done, 2);
  endsequence
  a_read_answer: assert property (host_req.rd_en |=> rd_valid) else $error("read not answered");
  a_no_stray: assert property (!host_req.rd_en |=> !rd_valid) else $error("stray read valid");
  a_data_holds: assert property (!$past(host_req.rd_en) |-> $stable(rd_data)) else $error("data moved");
  a_ready_set: assert property (s_conv |-> ##3 conversion_ready_flag) else $error("ready not set");
  a_ready_late: assert property ($rose(conversion_ready_flag) |-> $past(conv.conv_done, 3))
    else $error("ready set early");
  a_power_clear: assert property (host_req.rd_en && host_req.addr == PMR_ADDR_POWER ##0 s_no_set
    |=> !conversion_ready_flag) else $error("power read kept ready");
  a_mode_clear: assert property (mode_wr && !mode_off ##0 s_no_set |=> !conversion_ready_flag)
    else $error("mode write kept ready");
  a_mode_off_keep: assert property (mode_wr && mode_off && !host_req.rd_en && conversion_ready_flag
    |=> conversion_ready_flag) else $error("off mode cleared ready");
  a_cal_bit0: assert property (rd_valid && $past(host_req.addr) == PMR_ADDR_CAL |-> !rd_data[0])
    else $error("cal bit 0 set");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> rd_data == 16'h0000 && !rd_valid
    && !conversion_ready_flag && !math_overflow_flag) else $error("reset not clear");
endmodule
bind pmr_regs pmr_regs_monitor mon_u (.clk(clk), .rst(rst), .host_req(host_req), .rd_data(rd_data),
  .rd_valid(rd_valid), .conv(conv), .mode_wr(mode_wr), .mode_off(mode_off),
  .conversion_ready_flag(conversion_ready_flag), .math_overflow_flag(math_overflow_flag));
`default_nettype wire

// ### pmr_host_model.sv
// Purpose: Host side register access model
// Assumes: One request pulse per call
// Notes: Released fields show inverted values
`timescale 1ns/1ns
`default_nettype none
module pmr_host_model
  import pmr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Request out
  output pmr_host_req_type host_req
);
  initial host_req = '0;
  // One-cycle request, then release
  task automatic req(input logic r, input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #2 host_req = '{r, w, a, d};
    @(posedge clk);
    #2 host_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ### pmr_tb.sv
// Purpose: Self-checking bench for pmr_regs
// Assumes: 20 MHz clock, inputs moved 2 ns after edges
// Notes: Reads note expected data in a queue
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pmr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pmr_host_req_type host_req;
  pmr_conv_type conv = '0;
  logic mode_wr = 1'b0;
  logic mode_off = 1'b0;
  logic [15:0] rd_data;
  logic rd_valid;
  logic rdy;
  logic ovf_flag;
  logic [15:0] exp_q[$];
  logic [15:0] cal = 16'h0000;
  logic [15:0] sh;
  logic [12:0] bv;
  int n_fail = 0;
  int compares = 0;
  always #25 clk = ~clk;
  pmr_host_model host_u (.clk(clk), .host_req(host_req));
  pmr_regs dut_u (.clk(clk), .rst(rst), .host_req(host_req), .rd_data(rd_data), .rd_valid(rd_valid),
    .conv(conv), .mode_wr(mode_wr), .mode_off(mode_off), .conversion_ready_flag(rdy),
    .math_overflow_flag(ovf_flag));
  // Compare each answer with the oldest note
  always @(posedge clk)
  begin
    if (rd_valid === 1'b1)
    begin
      compares++;
      if (rd_data !== exp_q[0])
      begin
        n_fail++;
        $display("[ERR] %0t got %h exp %h", $time, rd_data, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host_u.req(1'b1, 1'b0, a, 16'h0000);
  endtask
  // Direct check of both flag outputs
  task automatic chk_flags(input logic er, input logic eo);
    compares++;
    if ({rdy, ovf_flag} !== {er, eo})
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, {rdy, ovf_flag}, {er, eo});
    end
  endtask
  task automatic md(input logic off);
    @(posedge clk);
    #2 mode_wr = 1'b1;
    mode_off = off;
    @(posedge clk);
    #2 mode_wr = 1'b0;
  endtask
  // Run one conversion and check results
  task automatic cnv(input logic r, input logic [12:0] bv, input logic [15:0] s);
    longint c;
    longint p;
    logic [15:0] f;
    logic o;
    @(posedge clk);
    #2 conv = '{1'b1, r, bv, s};
    @(posedge clk);
    #2 conv = '{1'b0, r, ~bv, ~s};
    repeat (3) @(posedge clk);
    c = (longint'($signed(s)) * longint'(cal)) >>> 12;
    f = r ? {1'b0, bv[11:0], 3'b000} : {bv, 3'b000};
    p = (c < 0 ? -c : c) * f[15:3] / 5000;
    o = c > 32767 || c < -32768;
    #2 chk_flags(1'b1, o);
    rd(PMR_ADDR_BUS_VOLT, f | 16'h0002 | 16'(o));
    rd(PMR_ADDR_CURRENT, c[15:0]);
    if (!o)
    begin
      rd(PMR_ADDR_POWER, p[15:0]);
      rd(PMR_ADDR_BUS_VOLT, f);
    end
    $display("test conversion done");
  endtask
  task automatic finish_test();
    if (exp_q.size() != 0)
      n_fail++;
    $display("compares %0d fails %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(31230));
    repeat (3) @(posedge clk);
    #2 rst = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      for (int a = 2; a < 8; a++)
        rd(8'(a), (k == 1 && a == 5) ? cal : 16'h0000);
      for (int a = 2; a < 5; a++)
        host_u.req(1'b0, 1'b1, 8'(a), 16'hffff);
      cal = 16'($urandom_range(8191)) | 16'h0001;
      host_u.req(1'b0, 1'b1, PMR_ADDR_CAL, cal);
      cal = cal & PMR_CAL_WR_MASK;
    end
    $display("test registers done");
    sh = 16'($urandom_range(4095));
    cnv(1'b0, 13'h1f40, sh);
    cnv(1'b0, 13'h1f40, -sh);
    cnv(1'b1, 13'h1fa0, sh);
    cal = 16'hfffe;
    host_u.req(1'b0, 1'b1, PMR_ADDR_CAL, 16'hffff);
    bv = 13'($urandom);
    cnv(1'b0, bv, 16'h7fff);
    md(1'b1);
    chk_flags(1'b1, 1'b1);
    rd(PMR_ADDR_BUS_VOLT, {bv, 3'b011});
    md(1'b0);
    chk_flags(1'b0, 1'b1);
    rd(PMR_ADDR_BUS_VOLT, {bv, 3'b001});
    repeat (4) @(posedge clk);
    $display("test mode done");
    finish_test();
  end
  // Watchdog
  initial
  begin
    #100000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
